// ===== rtl/tmsr_top.sv
// talk-mode responder and serial-poll status unit of a pattern generator
// assumes parser, pattern engine and bus handshake logic share i_mclk;
// only the poll-active pin comes from outside and is synchronised here
// ==========================================================
// Overview of operation
// RULE1: one string per configured segment with fields
// RULE2: final string gives address coding and strobe
// RULE3: controller reads segment count plus one strings
// RULE4: every segment is sent, displayed or not
// RULE5: data lines carry start-address and format mnemonics
// RULE6: too many channels flags and sends warning
// RULE7: error mode returns illegal character position
// RULE8: reply is SRQ, space, three padded digits
// RULE9: stored position kept until newer error
// RULE10: position reads zero before any error
// RULE11: errors and operator key raise SRQ, shown
// RULE12: serial poll drives status byte on data
// RULE13: upper nibble bits are independent flags
// RULE14: lower nibble holds four-bit message code
// RULE15: break bit refreshed on tick or command
// RULE16: run bit refreshed on tick or command
// RULE17: hardware or compatibility error flag bit
// RULE18: request bit marks change, read keeps status
// RULE19: timing and level errors hold error flag
// RULE20: quiet reporting hides SRQ for those errors
// RULE21: only latest error code is kept
// RULE22: SRQ released when serial poll completes
`timescale 1ns/1ns
module tmsr_top import tmsr_pkg::*; #(
  parameter int REFRESH_CYCLES = REFRESH_CYC
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_poll_active,
  output logic [7:0] o_dio,
  output logic o_dio_oe,
  output logic o_srq_oe,
  output logic o_srq_shown,
  input wire logic i_err_valid,
  input wire logic [3:0] i_err_code,
  input wire logic i_err_pos_valid,
  input wire logic [9:0] i_err_pos,
  input wire logic i_timing_err_active,
  input wire logic i_level_err_active,
  input wire logic i_report_select_valid,
  input wire logic [1:0] i_report_select_arg,
  input wire logic i_run,
  input wire logic i_break,
  input wire logic i_refresh_cmd,
  input wire logic i_seg_clear,
  input wire logic i_seg_append,
  input wire logic [SEG_DW-1:0] i_seg_desc,
  input wire logic [1:0] i_addr_coding,
  input wire logic i_strobe_entry,
  input wire logic i_talk_start,
  input wire logic [1:0] i_talk_mode,
  input wire logic [9:0] i_fmt_addr,
  input wire logic [15:0] i_fmt_word,
  output logic [7:0] o_talk_data,
  output logic o_talk_last,
  output logic o_talk_valid,
  input wire logic i_talk_ready,
  output logic o_talk_busy,
  output logic o_display_incomplete
);
  localparam int CNT_W = (REFRESH_CYCLES > 2) ? $clog2(REFRESH_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(REFRESH_CYCLES - 1);

  // ==========================================================
  // poll pin synchroniser and poll completion
  logic poll_s1;
  logic poll_s2;
  logic poll_s3;
  wire poll_done = poll_s3 & ~poll_s2;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      poll_s1 <= 1'b0;
      poll_s2 <= 1'b0;
      poll_s3 <= 1'b0;
    end else begin
      poll_s1 <= i_poll_active;
      poll_s2 <= poll_s1;
      poll_s3 <= poll_s2;
    end
  end

  // ==========================================================
  // status refresh divider
  logic [CNT_W-1:0] ref_cnt;
  wire tick = (ref_cnt == CNT_LAST);
  wire refresh = tick | i_refresh_cmd;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ref_cnt <= '0;
    end else begin
      ref_cnt <= tick ? '0 : ref_cnt + CNT_W'(1);
    end
  end

  // ==========================================================
  // poll condition byte
  logic run_flag;
  logic brk_flag;
  logic hw_flag;
  logic rqs;
  logic quiet;
  logic [3:0] code;
  logic [9:0] err_pos;
  wire is_tl = (i_err_code == CODE_TIMING) | (i_err_code == CODE_LEVEL);
  wire err_report = i_err_valid & ~(quiet & is_tl);
  wire next_rqs = err_report | (rqs & ~poll_done);
  wire next_hw = (i_err_valid & is_tl) | i_timing_err_active | i_level_err_active;
  wire [7:0] status = {brk_flag, rqs, hw_flag, run_flag, code};

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_flag <= 1'b0;
      brk_flag <= 1'b0;
      hw_flag <= 1'b0;
      rqs <= 1'b0;
      quiet <= 1'b0;
      code <= CODE_RST;
      err_pos <= ERR_POS_RST; // RULE10
    end else begin
      if (refresh) begin
        run_flag <= i_run; // RULE16
        brk_flag <= i_break; // RULE15
      end
      hw_flag <= next_hw; // RULE17 RULE19
      rqs <= next_rqs; // RULE11 RULE18 RULE22
      if (i_report_select_valid && i_report_select_arg == REPORT_QUIET) begin
        quiet <= 1'b1; // RULE20
      end else if (i_report_select_valid && i_report_select_arg == REPORT_NORMAL) begin
        quiet <= 1'b0;
      end
      if (i_err_valid) begin
        code <= i_err_code; // RULE14 RULE21
      end
      if (i_err_pos_valid) begin
        err_pos <= i_err_pos; // RULE9
      end
    end
  end

  // the byte is driven for the whole poll; completing the poll clears only the request bit
  assign o_dio = status; // RULE12 RULE13
  assign o_dio_oe = poll_s2;
  assign o_srq_oe = rqs; // RULE11
  assign o_srq_shown = rqs;

  // ==========================================================
  // segment table
  logic [3:0] seg_count;
  logic [7:0] total_ch;
  logic disp_inc;
  logic [SEG_AW-1:0] seg_raddr;
  logic [SEG_DW-1:0] seg_rdata;
  tmsr_seg_s new_seg;
  tmsr_seg_s rd_seg;
  wire seg_wr = i_seg_append & ~i_seg_clear & (seg_count < SEG_DEPTH_N);
  assign new_seg = tmsr_seg_s'(i_seg_desc);
  assign rd_seg = tmsr_seg_s'(seg_rdata);
  assign o_display_incomplete = disp_inc;

  tmsr_seg_mem u_mem (
    .i_mclk(i_mclk),
    .i_wr(seg_wr),
    .i_waddr(seg_count[SEG_AW-1:0]),
    .i_wdata(i_seg_desc),
    .i_raddr(seg_raddr),
    .o_rdata(seg_rdata)
  );

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seg_count <= 4'h0;
      total_ch <= 8'h00;
      disp_inc <= 1'b0;
    end else begin
      if (i_seg_clear) begin
        seg_count <= 4'h0;
        total_ch <= 8'h00;
      end else if (seg_wr) begin
        seg_count <= seg_count + 4'h1;
        total_ch <= total_ch + {3'h0, new_seg.nch};
      end
      disp_inc <= (total_ch > DISP_CH_CAP); // RULE6
    end
  end

  // ==========================================================
  // talker sequencer
  tmsr_talk_e state;
  tmsr_mode_e mode;
  logic [3:0] seg_idx;
  logic [5:0] ch_idx;
  logic [9:0] fmt_addr;
  logic [15:0] fmt_word;
  logic [7:0] line [LINE_MAX];
  logic [5:0] line_len;
  tmsr_stream_if in_if ();
  tmsr_stream_if out_if ();
  wire seg_final = (seg_idx == seg_count);
  wire start_ok = i_talk_start & (state == TK_IDLE);
  wire is_last = (ch_idx == line_len - 6'h01);
  wire fire = in_if.valid & in_if.ready;

  assign seg_raddr = seg_idx[SEG_AW-1:0];
  assign in_if.valid = (state == TK_EMIT);
  assign in_if.data = {is_last, line[ch_idx]};
  assign o_talk_busy = (state != TK_IDLE);

  // line image of the string being sent
  always_comb begin
    for (int k = 0; k < LINE_MAX; k++) begin
      line[k] = CH_SP;
    end
    line_len = LEN_ERR;
    unique case (mode)
      TMSR_FMT: begin
        {line[0], line[1], line[2]} = TXT_START; // RULE5
        line[4] = dec_ch(fmt_addr, 2'h2);
        line[5] = dec_ch(fmt_addr, 2'h1);
        line[6] = dec_ch(fmt_addr, 2'h0);
        {line[8], line[9], line[10]} = TXT_FORMAT;
        line[12] = hex_ch(fmt_word[15:12]);
        line[13] = hex_ch(fmt_word[11:8]);
        line[14] = hex_ch(fmt_word[7:4]);
        line[15] = hex_ch(fmt_word[3:0]);
        line_len = LEN_FMT;
        if (disp_inc) begin
          for (int k = 0; k < 18; k++) begin
            line[17 + k] = TXT_WARN[8 * (17 - k) +: 8]; // RULE6
          end
          line_len = LEN_FMT_WARN;
        end
      end
      TMSR_SEG: begin
        if (seg_final) begin
          unique case (tmsr_coding_e'(i_addr_coding))
            TMSR_DEC: {line[0], line[1], line[2]} = TXT_DEC;
            TMSR_OCT: {line[0], line[1], line[2]} = TXT_OCT;
            default: {line[0], line[1], line[2]} = TXT_HEX; // RULE2
          endcase
          line[4] = CH_S;
          line[5] = i_strobe_entry ? CH_Y : CH_N;
          line[6] = CH_E;
          line_len = LEN_LAST;
        end else begin
          unique case (tmsr_coding_e'(rd_seg.coding))
            TMSR_HEX: line[0] = CH_H;
            TMSR_DEC: line[0] = CH_D;
            TMSR_OCT: line[0] = CH_O;
            TMSR_BIN: line[0] = CH_B;
          endcase
          line[1] = rd_seg.entry ? CH_Y : CH_N; // RULE1
          line[3] = hex_ch(rd_seg.first_ch[7:4]);
          line[4] = hex_ch(rd_seg.first_ch[3:0]);
          line[6] = hex_ch(rd_seg.last_ch[7:4]);
          line[7] = hex_ch(rd_seg.last_ch[3:0]);
          line_len = LEN_SEG;
        end
      end
      default: begin
        {line[0], line[1], line[2]} = TXT_SRQ; // RULE8
        line[4] = dec_ch(err_pos, 2'h2); // RULE7
        line[5] = dec_ch(err_pos, 2'h1);
        line[6] = dec_ch(err_pos, 2'h0);
      end
    endcase
  end

  // a start while busy is ignored; strings never interleave
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= TK_IDLE;
      mode <= TMSR_ERR;
      seg_idx <= 4'h0;
      ch_idx <= 6'h00;
      fmt_addr <= 10'h000;
      fmt_word <= 16'h0000;
    end else begin
      unique case (state)
        TK_IDLE: begin
          if (start_ok) begin
            mode <= tmsr_mode_e'(i_talk_mode);
            fmt_addr <= i_fmt_addr;
            fmt_word <= i_fmt_word;
            seg_idx <= 4'h0;
            ch_idx <= 6'h00;
            state <= TK_LOAD;
          end
        end
        TK_LOAD: state <= TK_EMIT;
        TK_EMIT: begin
          if (fire && !is_last) begin
            ch_idx <= ch_idx + 6'h01;
          end else if (fire && mode == TMSR_SEG && !seg_final) begin
            seg_idx <= seg_idx + 4'h1; // RULE4
            ch_idx <= 6'h00;
            state <= TK_LOAD;
          end else if (fire) begin
            state <= TK_IDLE;
          end
        end
        default: state <= TK_IDLE;
      endcase
    end
  end

  // ==========================================================
  // output buffer, back-pressure stalls the sequencer
  assign out_if.ready = i_talk_ready;
  assign o_talk_data = out_if.data[7:0];
  assign o_talk_last = out_if.data[8];
  assign o_talk_valid = out_if.valid;

  tmsr_buf2 u_buf (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .s_in(in_if.snk),
    .s_out(out_if.src)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  AST_ERR_LEN: assert property ( // RULE8
    fire && mode == TMSR_ERR |-> (in_if.data[8] == (ch_idx == 6'h06))
  ) else $error("error reply length is not seven");
  AST_SRQ_SET: assert property ( // RULE11
    err_report |=> rqs && o_srq_oe && o_srq_shown
  ) else $error("error did not raise service request");
  AST_POLL_CLR: assert property ( // RULE22
    poll_done && !err_report |=> !o_srq_oe
  ) else $error("service request held after poll");
  AST_POLL_BYTE: assert property ( // RULE12
    $rose(i_poll_active) |-> ##2 o_dio_oe
  ) else $error("poll byte not driven");
  AST_LAST_CODE: assert property ( // RULE21
    i_err_valid |=> o_dio[3:0] == $past(i_err_code)
  ) else $error("latest error code not kept");
  AST_HW_HOLD: assert property ( // RULE19
    (i_timing_err_active || i_level_err_active) |=> o_dio[ST_HWERR]
  ) else $error("error flag dropped while error persists");
  AST_QUIET: assert property ( // RULE20
    quiet && i_err_valid && is_tl && !rqs |=> !rqs
  ) else $error("quiet error raised service request");
  AST_POS_KEEP: assert property ( // RULE9
    !i_err_pos_valid |=> $stable(err_pos)
  ) else $error("error position changed without error");
  AST_RUN_HOLD: assert property ( // RULE16
    !refresh |=> $stable(o_dio[ST_RUN]) && $stable(o_dio[ST_BREAK])
  ) else $error("run or break changed between refreshes");
  AST_SEG_NEXT: assert property ( // RULE1
    fire && is_last && mode == TMSR_SEG && !seg_final |=>
      state == TK_LOAD ##1 state == TK_EMIT && ch_idx == 6'h00
  ) else $error("segment string not followed by next");
  AST_WARN: assert property ( // RULE6
    total_ch > DISP_CH_CAP |=> o_display_incomplete
  ) else $error("display warning missing");

  COV_POLL: cover property (poll_done && rqs);
  COV_SEG_END: cover property (fire && is_last && mode == TMSR_SEG && seg_final);
  COV_ERR_REPLY: cover property (fire && is_last && mode == TMSR_ERR);
  COV_STALL: cover property (in_if.valid && !in_if.ready);
endmodule

// ===== rtl/tmsr_pkg.sv
// constants, types and helpers of the talk-mode and status responder
// assumes a single 10 MHz clock shared by every module of the block
package tmsr_pkg;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int REFRESH_MS = 50;
  localparam int REFRESH_CYC = REFRESH_MS * (CLK_HZ / 1000);

  // ==========================================================
  // poll condition byte layout and values
  localparam int ST_BREAK = 7;
  localparam int ST_RQS = 6;
  localparam int ST_HWERR = 5;
  localparam int ST_RUN = 4;
  localparam logic [3:0] CODE_RST = 4'h0;
  localparam logic [3:0] CODE_TIMING = 4'hd;
  localparam logic [3:0] CODE_LEVEL = 4'he;
  localparam logic [1:0] REPORT_NORMAL = 2'h1;
  localparam logic [1:0] REPORT_QUIET = 2'h2;
  localparam logic [9:0] ERR_POS_RST = 10'h000;

  // ==========================================================
  // segment table and text lines
  localparam int SEG_DEPTH = 8;
  localparam int SEG_AW = 3;
  localparam int SEG_DW = 24;
  localparam logic [3:0] SEG_DEPTH_N = 4'h8;
  localparam logic [7:0] DISP_CH_CAP = 8'h35;
  localparam int LINE_MAX = 36;
  localparam int STREAM_W = 9;
  localparam logic [5:0] LEN_ERR = 6'h07;
  localparam logic [5:0] LEN_FMT = 6'h10;
  localparam logic [5:0] LEN_FMT_WARN = 6'h23;
  localparam logic [5:0] LEN_SEG = 6'h08;
  localparam logic [5:0] LEN_LAST = 6'h07;

  typedef enum logic [1:0] {TMSR_FMT, TMSR_SEG, TMSR_ERR} tmsr_mode_e;
  typedef enum logic [1:0] {TMSR_HEX, TMSR_DEC, TMSR_OCT, TMSR_BIN} tmsr_coding_e;
  typedef enum logic [1:0] {TK_IDLE, TK_LOAD, TK_EMIT} tmsr_talk_e;

  typedef struct packed {
    logic [1:0] coding;
    logic entry;
    logic [7:0] first_ch;
    logic [7:0] last_ch;
    logic [4:0] nch;
  } tmsr_seg_s;

  // ==========================================================
  // characters
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_HEX_OFS = 8'h37;
  localparam logic [7:0] CH_Y = 8'h59;
  localparam logic [7:0] CH_N = 8'h4e;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_O = 8'h4f;
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [23:0] TXT_START = 24'h545341;
  localparam logic [23:0] TXT_FORMAT = 24'h464f52;
  localparam logic [23:0] TXT_SRQ = 24'h535251;
  localparam logic [23:0] TXT_HEX = 24'h484558;
  localparam logic [23:0] TXT_DEC = 24'h444543;
  localparam logic [23:0] TXT_OCT = 24'h4f4354;
  localparam logic [143:0] TXT_WARN = 144'h444953504c415920494e434f4d504c455445;

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    return (n < 4'ha) ? CH_0 + {4'h0, n} : CH_HEX_OFS + {4'h0, n};
  endfunction

  function automatic logic [7:0] dec_ch(input logic [9:0] v, input logic [1:0] p);
    logic [9:0] q;
    q = (p == 2'h2) ? v / 10'd100 : (p == 2'h1) ? v / 10'd10 : v;
    return CH_0 + {4'h0, 4'(q % 10'd10)};
  endfunction

endpackage

// ===== rtl/tmsr_stream_if.sv
// character stream between the line builder and the two-entry buffer
// assumes both ends on the same clock
`timescale 1ns/1ns
interface tmsr_stream_if import tmsr_pkg::*; ();
  logic [STREAM_W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

// ===== rtl/tmsr_seg_mem.sv
// segment descriptor store, one write port, registered read data
// assumes writes and reads on the same clock; read data lags address by one edge
`timescale 1ns/1ns
module tmsr_seg_mem import tmsr_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_wr,
  input wire logic [SEG_AW-1:0] i_waddr,
  input wire logic [SEG_DW-1:0] i_wdata,
  input wire logic [SEG_AW-1:0] i_raddr,
  output logic [SEG_DW-1:0] o_rdata
);
  // ==========================================================
  // storage; contents undefined until written, the count guards use
  logic [SEG_DW-1:0] mem [SEG_DEPTH];

  always_ff @(posedge i_mclk) begin
    if (i_wr) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// ===== rtl/tmsr_buf2.sv
// two-entry buffer so a stalled receiver loses no character
// assumes one clock and active-low asynchronous reset
`timescale 1ns/1ns
module tmsr_buf2 import tmsr_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  tmsr_stream_if.snk s_in,
  tmsr_stream_if.src s_out
);
  // ==========================================================
  // storage and pointers
  logic [STREAM_W-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire push = s_in.valid & s_in.ready;
  wire pop = s_out.valid & s_out.ready;

  assign s_in.ready = (count != 2'h2);
  assign s_out.valid = (count != 2'h0);
  assign s_out.data = mem[rd_ptr];

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      mem[0] <= '0;
      mem[1] <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= s_in.data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ===== dv/tmsr_ctrl_model.sv
// bus controller stand-in: gathers talker characters into strings, runs serial polls
// assumes the responder's talk stream and poll pins share its clock
`timescale 1ns/1ns
module tmsr_ctrl_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_talk_data,
  input wire logic i_talk_last,
  input wire logic i_talk_valid,
  output logic o_talk_ready,
  output logic o_poll_active,
  input wire logic [7:0] i_dio,
  input wire logic i_dio_oe,
  input wire logic i_slow
);
  // ==========================================================
  // string capture
  string lines[$];
  string cur = "";
  initial begin
    o_talk_ready = 1'b1;
    o_poll_active = 1'b0;
  end
  // slow mode stalls every other cycle so the buffer has to hold words
  always @(negedge i_mclk) o_talk_ready <= i_slow ? ~o_talk_ready : 1'b1;
  always @(posedge i_mclk) begin
    if (i_talk_valid === 1'b1 && o_talk_ready) begin
      // unknown characters become '?' so they can never match
      cur = {cur, $sformatf("%c", $isunknown(i_talk_data) ? 8'h3f : i_talk_data)};
      if (i_talk_last === 1'b1) begin
        lines.push_back(cur);
        cur = "";
      end
    end
  end
  // ==========================================================
  // serial poll: raise the pin, wait for the byte, take it, release
  task automatic do_poll(output logic [7:0] sb);
    @(negedge i_mclk);
    o_poll_active = 1'b1;
    for (int k = 0; k < 6 && i_dio_oe !== 1'b1; k++) @(negedge i_mclk);
    sb = (i_dio_oe === 1'b1) ? i_dio : 8'hxx;
    o_poll_active = 1'b0;
    repeat (4) @(negedge i_mclk);
  endtask
endmodule

// ===== dv/tb.sv
// self-checking bench of the talk-mode and status responder
// assumes the controller model drives the talk ready and poll pins
`timescale 1ns/1ns
module tb import tmsr_pkg::*;;
  // ==========================================================
  // signals
  logic i_mclk, i_reset_n, i_err_valid, i_err_pos_valid, i_timing_err_active;
  logic i_level_err_active, i_report_select_valid, i_run, i_break, i_refresh_cmd;
  logic i_seg_clear, i_seg_append, i_strobe_entry, i_talk_start, slow;
  logic [3:0] i_err_code;
  logic [9:0] i_err_pos, i_fmt_addr;
  logic [1:0] i_report_select_arg, i_addr_coding, i_talk_mode;
  logic [SEG_DW-1:0] i_seg_desc;
  logic [15:0] i_fmt_word;
  logic [7:0] o_dio, o_talk_data;
  logic o_dio_oe, o_srq_oe, o_srq_shown, o_talk_last, o_talk_valid, i_talk_ready;
  logic o_talk_busy, o_display_incomplete, i_poll_active;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  // 6 segments: channel total 28, then 53 (the capacity), then 54
  logic [23:0] segs [6] = '{{2'h0, 1'b1, 8'h33, 8'h00, 5'h10}, {2'h1, 1'b1, 8'h33, 8'h20, 5'h08},
    {2'h3, 1'b0, 8'h13, 8'h10, 5'h04}, {2'h2, 1'b1, 8'h3a, 8'h2b, 5'h10},
    {2'h3, 1'b1, 8'hf0, 8'h0c, 5'h09}, {2'h0, 1'b0, 8'h01, 8'h01, 5'h01}};

  tmsr_top #(.REFRESH_CYCLES(8)) uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_poll_active(i_poll_active), .o_dio(o_dio), .o_dio_oe(o_dio_oe), .o_srq_oe(o_srq_oe),
    .o_srq_shown(o_srq_shown), .i_err_valid(i_err_valid), .i_err_code(i_err_code),
    .i_err_pos_valid(i_err_pos_valid), .i_err_pos(i_err_pos),
    .i_timing_err_active(i_timing_err_active), .i_level_err_active(i_level_err_active),
    .i_report_select_valid(i_report_select_valid), .i_report_select_arg(i_report_select_arg),
    .i_run(i_run), .i_break(i_break), .i_refresh_cmd(i_refresh_cmd), .i_seg_clear(i_seg_clear),
    .i_seg_append(i_seg_append), .i_seg_desc(i_seg_desc), .i_addr_coding(i_addr_coding),
    .i_strobe_entry(i_strobe_entry), .i_talk_start(i_talk_start), .i_talk_mode(i_talk_mode),
    .i_fmt_addr(i_fmt_addr), .i_fmt_word(i_fmt_word), .o_talk_data(o_talk_data),
    .o_talk_last(o_talk_last), .o_talk_valid(o_talk_valid), .i_talk_ready(i_talk_ready),
    .o_talk_busy(o_talk_busy), .o_display_incomplete(o_display_incomplete));

  tmsr_ctrl_model ctrl (.i_mclk(i_mclk), .i_talk_data(o_talk_data), .i_talk_last(o_talk_last),
    .i_talk_valid(o_talk_valid), .o_talk_ready(i_talk_ready), .o_poll_active(i_poll_active),
    .i_dio(o_dio), .i_dio_oe(o_dio_oe), .i_slow(slow));

  always #50 i_mclk = ~i_mclk;

  // ==========================================================
  // checks and closing
  task automatic complete_run;
    $display("compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chks(input string got, input string exp);
    compares++;
    if (got != exp) begin
      n_fail++;
      $display("Error %0t: text got '%s' exp '%s'", $time, got, exp);
    end
  endtask
  // a hang in any wait ends the run here; the tests need well under a thousand cycles
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      $display("Error %0t: timeout", $time);
      complete_run;
    end
  end

  // ==========================================================
  // stimulus tasks, all driven at the falling edge
  task automatic err(input logic [3:0] code, input logic pv, input logic [9:0] pos);
    @(negedge i_mclk);
    i_err_valid = 1'b1;
    i_err_code = code;
    i_err_pos_valid = pv;
    i_err_pos = pos;
    @(negedge i_mclk);
    i_err_valid = 1'b0;
    i_err_pos_valid = 1'b0;
  endtask
  task automatic rsel(input logic [1:0] arg);
    @(negedge i_mclk);
    i_report_select_valid = 1'b1;
    i_report_select_arg = arg;
    @(negedge i_mclk);
    i_report_select_valid = 1'b0;
  endtask
  task automatic seg_add(input logic [23:0] d);
    @(negedge i_mclk);
    i_seg_desc = d;
    i_seg_append = 1'b1;
    @(negedge i_mclk);
    i_seg_append = 1'b0;
  endtask
  // start one talk, wait, bounded, for n strings, then check for exactly n and an idle talker
  task automatic talk(input logic [1:0] mode, input int n);
    ctrl.lines.delete();
    @(negedge i_mclk);
    i_talk_mode = mode;
    i_talk_start = 1'b1;
    @(negedge i_mclk);
    i_talk_start = 1'b0;
    for (int k = 0; k < 600 && ctrl.lines.size() < n; k++) @(negedge i_mclk);
    repeat (4) @(negedge i_mclk);
    chk(8'(ctrl.lines.size()), 8'(n), "string count");
    chk(8'(o_talk_busy), 8'h00, "talker busy");
  endtask
  task automatic pos_check(input logic [9:0] p);
    talk(2'h2, 1);
    chks(ctrl.lines[0], $sformatf("%s %03d", TXT_SRQ, p));
  endtask
  function automatic string seg_txt(input logic [23:0] d);
    string c = "HDOB";
    string s;
    s = $sformatf("%c%c %02h %02h", c[d[23:22]], d[21] ? CH_Y : CH_N, d[20:13], d[12:5]);
    return s.toupper();
  endfunction
  task automatic seg_check(input int n, input logic [1:0] cod, input logic sy);
    logic [23:0] cn [3] = '{TXT_HEX, TXT_DEC, TXT_OCT};
    i_addr_coding = cod;
    i_strobe_entry = sy;
    talk(2'h1, n + 1);
    for (int i = 0; i < n; i++) chks(ctrl.lines[i], seg_txt(segs[i]));
    chks(ctrl.lines[n], $sformatf("%s S%cE", cn[cod], sy ? CH_Y : CH_N));
  endtask
  task automatic fmt_check(input logic [9:0] a, input logic [15:0] w, input logic warn);
    string e;
    i_fmt_addr = a;
    i_fmt_word = w;
    talk(2'h0, 1);
    e = $sformatf("%s %03d %s %04h", TXT_START, a, TXT_FORMAT, w);
    e = e.toupper();
    if (warn) e = {e, $sformatf(" %s", TXT_WARN)};
    chks(ctrl.lines[0], e);
    chk(8'(o_display_incomplete), 8'(warn), "display incomplete");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] sb;
    {i_mclk, i_reset_n, i_err_valid, i_err_pos_valid, i_timing_err_active} = '0;
    {i_level_err_active, i_report_select_valid, i_run, i_break, i_refresh_cmd} = '0;
    {i_seg_clear, i_seg_append, i_strobe_entry, i_talk_start, slow} = '0;
    {i_err_code, i_err_pos, i_fmt_addr, i_report_select_arg} = '0;
    {i_addr_coding, i_talk_mode, i_seg_desc, i_fmt_word} = '0;
    repeat (10) @(negedge i_mclk);
    i_reset_n = 1'b1;
    chk(o_dio, 8'h00, "reset byte");
    chk(8'({o_srq_oe, o_srq_shown}), 8'h00, "reset srq");
    repeat (2) @(negedge i_mclk);
    pos_check(10'h000);
    err(4'h1, 1'b1, 10'h013);
    chk(o_dio, 8'h41, "syntax error byte");
    chk(8'({o_srq_oe, o_srq_shown}), 8'h03, "srq raised");
    pos_check(10'h013);
    err(4'h4, 1'b0, 10'h000);
    pos_check(10'h013);
    chk(o_dio, 8'h44, "latest code");
    ctrl.do_poll(sb);
    chk(sb, 8'h44, "first poll");
    chk(8'(o_srq_oe), 8'h00, "srq after poll");
    ctrl.do_poll(sb);
    chk(sb, 8'h04, "repeat poll");
    err(4'h0, 1'b0, 10'h000);
    chk(o_dio, 8'h40, "operator key");
    i_timing_err_active = 1'b1;
    err(4'hd, 1'b0, 10'h000);
    chk(o_dio, 8'h6d, "timing error");
    err(4'h3, 1'b0, 10'h000);
    chk(o_dio, 8'h63, "flag kept");
    i_timing_err_active = 1'b0;
    i_level_err_active = 1'b1;
    ctrl.do_poll(sb);
    rsel(2'h2);
    err(4'he, 1'b0, 10'h000);
    chk(o_dio, 8'h2e, "quiet level error");
    chk(8'(o_srq_oe), 8'h00, "quiet srq");
    rsel(2'h1);
    err(4'he, 1'b0, 10'h000);
    chk(o_dio, 8'h6e, "normal level error");
    i_level_err_active = 1'b0;
    @(negedge i_mclk);
    chk(o_dio, 8'h4e, "flag cleared");
    i_run = 1'b1;
    i_refresh_cmd = 1'b1;
    @(negedge i_mclk);
    i_refresh_cmd = 1'b0;
    chk(o_dio, 8'h5e, "run state");
    i_run = 1'b0;
    i_break = 1'b1;
    repeat (10) @(negedge i_mclk);
    chk(o_dio, 8'hce, "break state");
    i_level_err_active = 1'b1;
    err(4'h2, 1'b0, 10'h000);
    chk(o_dio, 8'he2, "flags together");
    i_level_err_active = 1'b0;
    i_break = 1'b0;
    @(negedge i_mclk);
    i_seg_clear = 1'b1;
    @(negedge i_mclk);
    i_seg_clear = 1'b0;
    for (int i = 0; i < 3; i++) seg_add(segs[i]);
    for (int c = 0; c < 3; c++) seg_check(3, 2'(c), c[0]);
    fmt_check(10'h3e7, 16'hab3c, 1'b0);
    seg_add(segs[3]);
    seg_add(segs[4]);
    fmt_check(10'h000, 16'h0f9e, 1'b0);
    seg_add(segs[5]);
    slow = 1'b1;
    fmt_check(10'h005, 16'hf00d, 1'b1);
    seg_check(6, 2'h0, 1'b1);
    slow = 1'b0;
    complete_run;
  end
endmodule
